// ---- hdl/netstop_pkg.sv ----
// Package: register map, field positions and constants of the network stop hold block
package netstop_pkg;
  // Register map (word addresses on the plain port)
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_MAIL_RX_CTRL = 4'h1;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h2;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h3;
  localparam logic [3:0] ADDR_HOLD_STATUS = 4'h4;
  localparam logic [3:0] ADDR_RECEIVE_FLAGS = 4'h5;
  localparam logic [3:0] ADDR_LINK_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_MEMBER_FLAGS = 4'h7;
  // Control register fields
  localparam int CTL_RUN_BIT = 0;
  localparam int CTL_GMM_BIT = 1;
  // Mail receive control: receive ready bit
  localparam int RX_READY_BIT = 6;
  // Interrupt status fields
  localparam int IRQ_REQ_STOP_BIT = 0;
  localparam int IRQ_SNF_BIT = 1;
  localparam int IRQ_OOC_BIT = 2;
  localparam int IRQ_WIDTH = 3;
  // Station arithmetic
  localparam int STATION_BITS = 6;
  localparam int STATIONS = 64;
  localparam logic [STATION_BITS:0] HOLD_SPAN_MIN = 7'h02;
  // Stop reasons
  typedef enum logic [1:0] {
    STOP_NONE,
    STOP_REQUESTED,
    STOP_SNF,
    STOP_OOC
  } stop_reason_e;
endpackage : netstop_pkg

// ---- hdl/network_stop_status_hold.sv ----
// Network stop detection, flag holding after out-of-cycle stop and its release
//
// Summary of operation
// - Stops are requested (run bit written 0) or faults (not found, out of cycle).
// - Out-of-cycle stop with final minus own above 2 freezes all flag registers.
// - While held, member monitor low if any other station's member flag is 1.
// - Hold released by monitor mode, hardware reset, or expanded resizing over own area.
// - On release, link and member flags clear and member monitor goes high.
// - After reset or resize release, shared memory is not refreshed from frames.
// - While monitor mode is active, shared memory keeps updating from frames.
// - Receive ready bit is writable only while run bit is 1.
// - Run bit falling to 0 clears a set receive ready bit.
// - Stop interrupt on run bit written 0, not-found stop, or out-of-cycle stop.
//
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module network_stop_status_hold
  import netstop_pkg::*;
#(
  parameter int NUM_STATIONS = STATIONS
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [31:0] reg_rdata_o,
  // Network engine side
  input wire logic station_not_found_i,
  input wire logic out_of_cycle_i,
  input wire logic expanded_resize_i,
  input wire logic frame_update_i,
  input wire logic [STATION_BITS-1:0] final_station_i,
  input wire logic [STATION_BITS-1:0] own_station_number_i,
  input wire logic [NUM_STATIONS-1:0] live_receive_flags_i,
  input wire logic [NUM_STATIONS-1:0] live_link_flags_i,
  input wire logic [NUM_STATIONS-1:0] live_member_flags_i,
  // Outputs
  output logic run_o,
  output logic global_memory_monitor_o,
  output logic shared_memory_write_en_o,
  output logic flags_held_o,
  output logic member_monitor_n_o,
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  // The station number is six bits wide, so the flag vectors must cover
  // exactly every station it can name; a shorter vector would let the
  // member monitor mask index past its top bit, a longer one would carry
  // bits that no station number ever selects.
  if (NUM_STATIONS != STATIONS) begin : g_bad_station_count
    $error("NUM_STATIONS must equal 64 to match the station number width");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  // run         software run request, also dropped by a fault stop
  // gmm         monitor mode, releases a hold and keeps memory fed
  // rx_ready    mail receive ready, only alive while running
  // irq_status  sticky stop causes, write one to clear
  // irq_mask    enables of the stop causes towards the interrupt pin
  // held        flag registers frozen after a wide out-of-cycle stop
  // refresh_en  shared memory may be written from received frames
  // stopped     network is not running, whatever the cause
  // Every output below is a register so that the pins never glitch
  // while the decode logic settles.
  logic run, next_run;
  logic global_memory_monitor, next_gmm;
  logic rx_ready, next_rx_ready;
  logic [IRQ_WIDTH-1:0] irq_status, next_irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask, next_irq_mask;
  logic held, next_held;
  logic refresh_en, next_refresh_en;
  logic stopped, next_stopped;
  logic [NUM_STATIONS-1:0] receive_flag_reg, next_receive_flag_reg;
  logic [NUM_STATIONS-1:0] link_flag_reg, next_link_flag_reg;
  logic [NUM_STATIONS-1:0] member_flag_reg, next_member_flag_reg;
  logic [31:0] rdata, next_rdata;
  logic monitor_n, next_monitor_n;
  logic irq_q, next_irq_q;
  logic mem_we, next_mem_we;

  logic wr_control, wr_rx_ctrl, wr_status, wr_mask;
  logic [STATION_BITS:0] span;
  logic [NUM_STATIONS-1:0] others_mask;
  logic snf_event, ooc_event, req_stop_event;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and events
  // The engine inputs come from logic on this same clock, so they are
  // read directly with no synchroniser in front of them.
  // Faults are qualified by run: a fault reported while already stopped
  // must not set a second status bit or move the hold.
  assign wr_control = reg_write_i && (reg_addr_i == ADDR_CONTROL);
  assign wr_rx_ctrl = reg_write_i && (reg_addr_i == ADDR_MAIL_RX_CTRL);
  assign wr_status = reg_write_i && (reg_addr_i == ADDR_IRQ_STATUS);
  assign wr_mask = reg_write_i && (reg_addr_i == ADDR_IRQ_MASK);
  assign span = {1'b0, final_station_i} - {1'b0, own_station_number_i};
  assign others_mask = ~(NUM_STATIONS'(1) << own_station_number_i);
  // Fault stops count only while running
  assign snf_event = run && station_not_found_i;
  assign ooc_event = run && out_of_cycle_i;
  // Requested stop on run written 0
  assign req_stop_event = run && wr_control && !reg_wdata_i[CTL_RUN_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Control, interrupt and hold next-state
  // Order of the statements below matters: later ones win.
  // Hazard: a release and a fresh out-of-cycle stop in one cycle are
  // resolved in favour of the release, since monitor mode or a resize
  // means the network has already been taken over by software.
  always_comb begin
    next_run = run;
    next_gmm = global_memory_monitor;
    next_rx_ready = rx_ready;
    next_irq_mask = irq_mask;
    next_irq_status = irq_status;
    next_held = held;
    next_refresh_en = refresh_en;
    next_stopped = stopped;
    if (wr_control) begin
      next_run = reg_wdata_i[CTL_RUN_BIT];
      next_gmm = reg_wdata_i[CTL_GMM_BIT];
    end
    // A fault stop drops the run bit, same as software would
    if (snf_event || ooc_event) begin
      next_run = 1'b0;
    end
    if (next_run && !run) begin
      next_stopped = 1'b0;
      next_refresh_en = 1'b1;
    end
    if (req_stop_event || snf_event || ooc_event) begin
      next_stopped = 1'b1;
    end
    // Ready bit only writable while running
    if (wr_rx_ctrl && run) begin
      next_rx_ready = reg_wdata_i[RX_READY_BIT];
    end
    if (!next_run) begin
      next_rx_ready = 1'b0;
    end
    if (wr_mask) begin
      next_irq_mask = reg_wdata_i[IRQ_WIDTH-1:0];
    end
    // Write one to clear; a new event in the same cycle wins
    if (wr_status) begin
      next_irq_status = irq_status & ~reg_wdata_i[IRQ_WIDTH-1:0];
    end
    if (req_stop_event) begin
      next_irq_status[IRQ_REQ_STOP_BIT] = 1'b1;
    end
    if (snf_event) begin
      next_irq_status[IRQ_SNF_BIT] = 1'b1;
    end
    if (ooc_event) begin
      next_irq_status[IRQ_OOC_BIT] = 1'b1;
    end
    // Freeze only when span exceeds two
    if (ooc_event && (span > HOLD_SPAN_MIN)) begin
      next_held = 1'b1;
    end
    if (ooc_event && (span <= HOLD_SPAN_MIN)) begin
      next_held = held;
    end
    // Release by monitor mode or expanded resize
    if (held && (global_memory_monitor || expanded_resize_i)) begin
      next_held = 1'b0;
    end
    // Resize release stops frame refresh of shared memory
    if (held && expanded_resize_i && !global_memory_monitor) begin
      next_refresh_en = 1'b0;
    end
    if (global_memory_monitor) begin
      next_refresh_en = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag registers next-state
  // While stopped and not in monitor mode the flags keep their last
  // value; the live vectors are only meaningful while the link runs.
  // Limitation: the receive flags are not cleared on release.
  always_comb begin
    next_receive_flag_reg = receive_flag_reg;
    next_link_flag_reg = link_flag_reg;
    next_member_flag_reg = member_flag_reg;
    if (held && !next_held) begin
      // Release clears link and member flags
      next_link_flag_reg = '0;
      next_member_flag_reg = '0;
    end else if (next_held) begin
      // Values from just before the stop stay put
      next_receive_flag_reg = receive_flag_reg;
    end else if (!stopped || global_memory_monitor) begin
      next_receive_flag_reg = live_receive_flags_i;
      next_link_flag_reg = live_link_flags_i;
      next_member_flag_reg = live_member_flags_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output and read data next-state
  // Read data are zero outside the cycle after a read strobe, so a bus
  // that ORs several slaves together needs no extra gating.
  // The lamp and interrupt look at next values, which keeps them in
  // step with the registers they describe rather than a cycle behind.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_read_i) begin
      case (reg_addr_i)
        ADDR_CONTROL: begin
          next_rdata[CTL_RUN_BIT] = run;
          next_rdata[CTL_GMM_BIT] = global_memory_monitor;
        end
        ADDR_MAIL_RX_CTRL: next_rdata[RX_READY_BIT] = rx_ready;
        ADDR_IRQ_STATUS: next_rdata[IRQ_WIDTH-1:0] = irq_status;
        ADDR_IRQ_MASK: next_rdata[IRQ_WIDTH-1:0] = irq_mask;
        ADDR_HOLD_STATUS: next_rdata[1:0] = {stopped, held};
        ADDR_RECEIVE_FLAGS: next_rdata = receive_flag_reg[31:0];
        ADDR_LINK_FLAGS: next_rdata = link_flag_reg[31:0];
        ADDR_MEMBER_FLAGS: next_rdata = member_flag_reg[31:0];
        default: next_rdata = 32'h0000_0000;
      endcase
    end
    // Held member flag of another station lights monitor
    next_monitor_n = !(next_held && |(next_member_flag_reg & others_mask));
    next_irq_q = |(next_irq_status & next_irq_mask);
    // Memory written from frames only when allowed
    next_mem_we = frame_update_i && next_refresh_en && (!next_stopped || next_gmm);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // One register process for every group; reset is synchronous so the
  // reset branch only loads constants.
  // Stopped is set at reset because the network is not running yet.
  // Hardware reset also releases the hold; and disables refresh
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      run <= 1'b0;
      global_memory_monitor <= 1'b0;
      rx_ready <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      held <= 1'b0;
      refresh_en <= 1'b0;
      stopped <= 1'b1;
      receive_flag_reg <= '0;
      link_flag_reg <= '0;
      member_flag_reg <= '0;
      rdata <= 32'h0000_0000;
      monitor_n <= 1'b1;
      irq_q <= 1'b0;
      mem_we <= 1'b0;
    end else begin
      run <= next_run;
      global_memory_monitor <= next_gmm;
      rx_ready <= next_rx_ready;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      held <= next_held;
      refresh_en <= next_refresh_en;
      stopped <= next_stopped;
      receive_flag_reg <= next_receive_flag_reg;
      link_flag_reg <= next_link_flag_reg;
      member_flag_reg <= next_member_flag_reg;
      rdata <= next_rdata;
      monitor_n <= next_monitor_n;
      irq_q <= next_irq_q;
      mem_we <= next_mem_we;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Straight from the registers above, no logic in between.
  assign reg_rdata_o = rdata;
  assign run_o = run;
  assign global_memory_monitor_o = global_memory_monitor;
  assign shared_memory_write_en_o = mem_we;
  assign flags_held_o = held;
  assign member_monitor_n_o = monitor_n;
  assign irq_o = irq_q;

  // Nothing else is driven from here; the engine owns the live flags
  // and the shared memory itself, this block only gates its writes.

endmodule : network_stop_status_hold

// ---- test/netstop_chk.sv ----
// Checker: port-level properties of the network stop hold block
`timescale 1ns/100ps
module netstop_chk
  import netstop_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic reg_write_i,
  input wire logic station_not_found_i,
  input wire logic out_of_cycle_i,
  input wire logic expanded_resize_i,
  input wire logic frame_update_i,
  input wire logic [STATION_BITS-1:0] final_station_i,
  input wire logic [STATION_BITS-1:0] own_station_number_i,
  input wire logic run_o,
  input wire logic global_memory_monitor_o,
  input wire logic shared_memory_write_en_o,
  input wire logic flags_held_o,
  input wire logic member_monitor_n_o
);
  logic [STATION_BITS:0] span;
  logic ooc_run;
  // Span wraps modulo, so a negative difference counts as wide
  assign span = {1'b0, final_station_i} - {1'b0, own_station_number_i};
  assign ooc_run = run_o && out_of_cycle_i && !reg_write_i;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // Hold dropped and lamp dark together
  sequence cleared_s;
    !flags_held_o && member_monitor_n_o;
  endsequence
  stop_on_fault_a: assert property (run_o && (station_not_found_i || out_of_cycle_i)
    && !reg_write_i |=> !run_o) else $error("run survived fault");
  hold_wide_a: assert property (ooc_run && span > HOLD_SPAN_MIN |=> flags_held_o)
    else $error("hold not set");
  hold_narrow_a: assert property (ooc_run && span <= HOLD_SPAN_MIN && !flags_held_o
    |=> !flags_held_o) else $error("narrow span held");
  monitor_low_a: assert property (!member_monitor_n_o |-> flags_held_o)
    else $error("monitor low without hold");
  resize_free_a: assert property (flags_held_o && expanded_resize_i |=> cleared_s)
    else $error("resize did not release");
  gmm_free_a: assert property (flags_held_o && global_memory_monitor_o |=> cleared_s)
    else $error("monitor mode did not release");
  gmm_refresh_a: assert property (global_memory_monitor_o && frame_update_i && !reg_write_i
    |=> shared_memory_write_en_o) else $error("frame lost in monitor mode");
  reset_stale_a: assert property ($fell(reset_i) |-> !shared_memory_write_en_o)
    else $error("refresh after reset");
endmodule : netstop_chk

bind network_stop_status_hold netstop_chk i_chk (.sys_clk_i, .reset_i, .reg_write_i,
  .station_not_found_i, .out_of_cycle_i, .expanded_resize_i, .frame_update_i,
  .final_station_i, .own_station_number_i, .run_o, .global_memory_monitor_o,
  .shared_memory_write_en_o, .flags_held_o, .member_monitor_n_o);

// ---- test/network_stop_status_hold_tb.sv ----
// Testbench: network stop detection, flag hold and its release
`timescale 1ns/100ps
module network_stop_status_hold_tb
  import netstop_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [31:0] reg_rdata;
  logic [1:0] fault_cmd = 2'h0;
  logic resize_cmd = 1'b0;
  logic [63:0] pattern = 64'h0;
  logic [5:0] final_station = 6'h14;
  logic station_not_found, ooc, resize, frame, run, global_memory_monitor, sm_we, held, mon_n, irq;
  logic [63:0] flags;
  int failures = 0;
  int samples_checked = 0;
  network_stop_status_hold i_dut (.sys_clk_i(sys_clk), .reset_i(reset),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_write_i(reg_write),
    .reg_read_i(reg_read), .reg_rdata_o(reg_rdata), .station_not_found_i(station_not_found),
    .out_of_cycle_i(ooc), .expanded_resize_i(resize), .frame_update_i(frame),
    .final_station_i(final_station), .own_station_number_i(6'h05),
    .live_receive_flags_i(flags), .live_link_flags_i(flags), .live_member_flags_i(flags),
    .run_o(run), .global_memory_monitor_o(global_memory_monitor), .shared_memory_write_en_o(sm_we),
    .flags_held_o(held), .member_monitor_n_o(mon_n), .irq_o(irq));
  peer_model i_peer (.sys_clk_i(sys_clk), .fault_cmd_i(fault_cmd), .resize_cmd_i(resize_cmd),
    .pattern_i(pattern), .station_not_found_o(station_not_found), .out_of_cycle_o(ooc),
    .expanded_resize_o(resize), .frame_update_o(frame), .flags_o(flags));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  task automatic pulse(input logic [1:0] k, input logic r);
    @(posedge sys_clk);
    fault_cmd <= k;
    resize_cmd <= r;
    @(posedge sys_clk);
    fault_cmd <= 2'h0;
    resize_cmd <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : pulse
  task automatic t_ready();
    rd(ADDR_HOLD_STATUS, 32'h2);
    rd(4'hf, 32'h0);
    wr(ADDR_MAIL_RX_CTRL, 32'h40);
    rd(ADDR_MAIL_RX_CTRL, 32'h0);
    wr(ADDR_CONTROL, 32'h1);
    wr(ADDR_MAIL_RX_CTRL, 32'h40);
    rd(ADDR_MAIL_RX_CTRL, 32'h40);
    wr(ADDR_CONTROL, 32'h0);
    rd(ADDR_MAIL_RX_CTRL, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h7);
  endtask : t_ready
  task automatic t_snf();
    wr(ADDR_IRQ_MASK, 32'h2);
    wr(ADDR_CONTROL, 32'h1);
    pulse(2'h1, 1'b0);
    chk(32'(run), 32'h0);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_MASK, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h2);
    chk(32'(irq), 32'h0);
    wr(ADDR_IRQ_STATUS, 32'h2);
    rd(ADDR_IRQ_STATUS, 32'h0);
  endtask : t_snf
  // Out-of-cycle stop: hold on wide span only, lamp per other stations
  task automatic t_ooc(input logic [63:0] p, input logic [5:0] f, input logic h, input logic m);
    pattern <= p;
    final_station <= f;
    pulse(2'h3, 1'b0);
    wr(ADDR_CONTROL, 32'h1);
    pulse(2'h2, 1'b0);
    chk(32'(held), 32'(h));
    chk(32'(mon_n), 32'(m));
    if (h) rd(ADDR_MEMBER_FLAGS, p[31:0]);
    if (h) rd(ADDR_LINK_FLAGS, p[31:0]);
    wr(ADDR_IRQ_STATUS, 32'h7);
  endtask : t_ooc
  task automatic t_resize();
    pulse(2'h0, 1'b1);
    chk(32'(held), 32'h0);
    chk(32'(mon_n), 32'h1);
    rd(ADDR_MEMBER_FLAGS, 32'h0);
    rd(ADDR_LINK_FLAGS, 32'h0);
    chk(32'(sm_we), 32'h0);
  endtask : t_resize
  task automatic t_gmm();
    logic seen;
    seen = 1'b0;
    wr(ADDR_CONTROL, 32'h2);
    repeat (3) @(posedge sys_clk);
    chk(32'(held), 32'h0);
    chk(32'(mon_n), 32'h1);
    repeat (4) @(posedge sys_clk) #1 seen |= sm_we;
    chk(32'(seen), 32'h1);
    wr(ADDR_CONTROL, 32'h0);
  endtask : t_gmm
  task automatic t_hw_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1 chk(32'(held), 32'h0);
    chk(32'(mon_n), 32'h1);
    chk(32'(sm_we), 32'h0);
  endtask : t_hw_reset
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Watchdog well beyond the roughly 150 cycles the run needs
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    summarize();
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_ready();
    t_snf();
    t_ooc(64'h20, 6'h14, 1'b1, 1'b1);
    t_resize();
    t_ooc(64'h21, 6'h14, 1'b1, 1'b0);
    t_gmm();
    t_ooc(64'h21, 6'h07, 1'b0, 1'b1);
    t_ooc(64'h21, 6'h08, 1'b1, 1'b0);
    t_hw_reset();
    summarize();
  end
endmodule : network_stop_status_hold_tb

// ---- test/peer_model.sv ----
// Partner: peer stations and network engine seen by the hold block
`timescale 1ns/100ps
module peer_model (
  input wire logic sys_clk_i,
  input wire logic [1:0] fault_cmd_i,
  input wire logic resize_cmd_i,
  input wire logic [63:0] pattern_i,
  output logic station_not_found_o,
  output logic out_of_cycle_o,
  output logic expanded_resize_o,
  output logic frame_update_o,
  output logic [63:0] flags_o
);
  logic flip;
  initial begin
    {station_not_found_o, out_of_cycle_o, expanded_resize_o, frame_update_o, flip} = 5'h0;
  end
  // fault kinds
  // Flags invert after a fault, so a late freeze shows wrong values
  always @(posedge sys_clk_i) begin
    station_not_found_o <= fault_cmd_i == 2'h1;
    out_of_cycle_o <= fault_cmd_i == 2'h2;
    expanded_resize_o <= resize_cmd_i;
    frame_update_o <= !frame_update_o;
    // Command 3 restarts the peers with fresh, uninverted flags
    flip <= (fault_cmd_i != 2'h3)
      && (station_not_found_o || out_of_cycle_o || (flip && !expanded_resize_o));
  end
  assign flags_o = flip ? ~pattern_i : pattern_i;
endmodule : peer_model
